// [core/adc_seq_pkg.sv]
// Package with register map, field layouts and timing constants for the converter sequencer.
package adc_seq_pkg;

    // =====================================
    // Register byte addresses on APB.
    localparam logic [7:0] ADDR_MAIN_CTRL = 8'h00;
    localparam logic [7:0] ADDR_REF_PIN_CTRL = 8'h04;
    localparam logic [7:0] ADDR_TIMING_CTRL = 8'h08;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h0c;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h10;
    localparam logic [7:0] ADDR_FLAG_CTRL = 8'h14;

    // =====================================
    // Field positions.
    localparam int MAIN_ENABLE_BIT = 0;
    localparam int MAIN_BUSY_BIT = 1;
    localparam int TIMING_JUSTIFY_BIT = 7;
    localparam int FLAG_DONE_BIT = 0;
    localparam int FLAG_IRQ_EN_BIT = 1;
    localparam logic [7:0] MAIN_WMASK = 8'h3f;
    localparam logic [7:0] REF_PIN_WMASK = 8'h3f;
    localparam logic [7:0] TIMING_WMASK = 8'hbf;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] REF_BOTH_EXTERNAL = 2'h3;

    // =====================================
    // Timing constants.
    localparam int CONV_PERIODS = 13;
    localparam int GAP_PERIODS = 2;
    localparam int CLK_FREQ_MHZ = 100;
    // Instruction cycle time in ns and its count in clocks.
    localparam int TCY_NS = 40;
    localparam int TCY_CYCLES = (TCY_NS * CLK_FREQ_MHZ + 999) / 1000;
    // Internal RC half period in system clocks (stand-in for the RC oscillator).
    localparam int RC_HALF_CYCLES = 125;
    localparam int RESULT_BITS = 12;

    typedef enum {ST_IDLE, ST_DELAY, ST_ACQ, ST_CONV, ST_GAP} seq_state_e;

    // Analog-side controls grouped together.
    typedef struct packed {
        logic [3:0] channel;
        logic sample_connect;
        logic ref_pos_external;
        logic ref_neg_external;
        logic [15:0] analog_mode;
    } analog_ctrl_s;

endpackage

// [core/sar_engine.sv]
// Successive-approximation register engine stepped by conversion clock ticks.
`timescale 1ns/100ps
module sar_engine
    import adc_seq_pkg::*;
(
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic start, // Load trial pattern for a new conversion.
    input wire logic step, // One bit decision per pulse.
    input wire logic comp_high, // Comparator: sample at or above the trial value.
    output logic [11:0] trial, // Current trial value to the DAC.
    output logic [11:0] code // Accumulated code.
);

    logic [11:0] bit_mask; // Bit currently under test.

    // =====================================
    // Bit-by-bit decision.
    // twelve bit search
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_mask <= 12'h000;
            code <= 12'h000;
        end else if (start) begin
            bit_mask <= 12'h800;
            code <= 12'h000;
        end else if (step && bit_mask != 12'h000) begin
            // Keep the bit when the sample is at or above the trial level.
            if (comp_high) begin
                code <= code | bit_mask;
            end
            bit_mask <= bit_mask >> 1;
        end
    end

    // Trial value is the code so far plus the bit under test.
    assign trial = code | bit_mask;

endmodule

// [core/sar_adc_sequencer.sv]
// Top of the converter sequencer: APB registers, clock select, acquisition and conversion control.
`timescale 1ns/100ps
module sar_adc_sequencer
    import adc_seq_pkg::*;
(
    input wire logic pclk, // System clock, 100 MHz.
    input wire logic presetn, // Device reset, asynchronous, active low.
    input wire logic por_n, // Power-on or brown-out reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    input wire logic [3:0] pstrb, // APB byte strobes.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic sleep_mode, // Device sleeping: system divider stopped.
    input wire logic comp_high, // Comparator output from the analog array.
    output logic [11:0] dac_trial, // Trial value to the capacitor DAC.
    output analog_ctrl_s analog_ctrl, // Channel, switch and reference controls.
    output logic conv_irq // Done flag gated by its enable.
);

    // =====================================
    // Registers.
    logic [7:0] main_ctrl; // Channel, busy, enable.
    logic [7:0] ref_pin_ctrl; // Reference and pin configuration.
    logic [7:0] timing_ctrl; // Justify, acquisition, clock select.
    logic [7:0] result_high; // Result high byte.
    logic [7:0] result_low; // Result low byte.
    logic done_flag; // Conversion done, sticky.
    logic irq_enable; // Interrupt enable.
    seq_state_e state; // Sequencer state.
    logic [4:0] tick_count; // Conversion-clock periods in current phase.
    logic [6:0] div_count; // Divider counter.
    logic [7:0] rc_count; // Internal RC oscillator stand-in.
    logic [2:0] delay_count; // Instruction-cycle delay before RC start.
    logic tick; // One conversion-clock period elapsed.
    logic wr_en; // APB write strobe.
    logic sar_start; // Load the SAR engine.
    logic [11:0] sar_code; // SAR result.
    logic done_event; // Conversion just completed.
    logic busy_set; // Software start request.
    logic busy_clear_sw; // Software abort.

    // =====================================
    // Decoding functions.
    // acquisition periods
    function automatic logic [4:0] acq_periods(input logic [2:0] sel);
        case (sel)
            3'h0: acq_periods = 5'd0;
            3'h1: acq_periods = 5'd2;
            3'h2: acq_periods = 5'd4;
            3'h3: acq_periods = 5'd6;
            3'h4: acq_periods = 5'd8;
            3'h5: acq_periods = 5'd12;
            3'h6: acq_periods = 5'd16;
            default: acq_periods = 5'd20;
        endcase
    endfunction

    function automatic logic [6:0] div_ratio(input logic [2:0] sel);
        case (sel)
            3'h0: div_ratio = 7'd2;
            3'h1: div_ratio = 7'd8;
            3'h2: div_ratio = 7'd32;
            3'h4: div_ratio = 7'd4;
            3'h5: div_ratio = 7'd16;
            3'h6: div_ratio = 7'd64;
            default: div_ratio = 7'd0;
        endcase
    endfunction

    function automatic logic is_rc(input logic [2:0] sel);
        is_rc = (sel[1:0] == 2'h3);
    endfunction

    // =====================================
    // APB slave: zero wait states, error on unmapped address.
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite && pstrb[0];

    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (paddr == ADDR_MAIN_CTRL) begin
            prdata[7:0] = main_ctrl;
        end else if (paddr == ADDR_REF_PIN_CTRL) begin
            prdata[7:0] = ref_pin_ctrl;
        end else if (paddr == ADDR_TIMING_CTRL) begin
            prdata[7:0] = timing_ctrl & TIMING_WMASK;
        end else if (paddr == ADDR_RESULT_HIGH) begin
            prdata[7:0] = result_high;
        end else if (paddr == ADDR_RESULT_LOW) begin
            prdata[7:0] = result_low;
        end else if (paddr == ADDR_FLAG_CTRL) begin
            prdata[FLAG_DONE_BIT] = done_flag;
            prdata[FLAG_IRQ_EN_BIT] = irq_enable;
        end else begin
            pslverr = psel && penable;
        end
    end

    // Start and abort requests decoded from a write to the main register.
    // start needs enable
    assign busy_set = wr_en && paddr == ADDR_MAIN_CTRL && pwdata[MAIN_BUSY_BIT] && pwdata[MAIN_ENABLE_BIT]
                      && !main_ctrl[MAIN_BUSY_BIT];
    assign busy_clear_sw = wr_en && paddr == ADDR_MAIN_CTRL && !pwdata[MAIN_BUSY_BIT];

    // =====================================
    // Main control register; hardware completion clears the busy bit.
    // reset clears controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_ctrl <= CTRL_RESET;
        end else if (wr_en && paddr == ADDR_MAIN_CTRL) begin
            // A write that clears the enable bit cannot leave the busy bit set; a completion in this cycle still clears it.
            main_ctrl <= pwdata[7:0] & MAIN_WMASK & {6'h3f, busy_set || (main_ctrl[MAIN_BUSY_BIT] && !done_event), 1'b1};
            if (!pwdata[MAIN_ENABLE_BIT]) begin
                main_ctrl[MAIN_BUSY_BIT] <= 1'b0;
            end
        end else if (done_event) begin
            main_ctrl[MAIN_BUSY_BIT] <= 1'b0;
        end
    end

    // Configuration registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_pin_ctrl <= CTRL_RESET;
            timing_ctrl <= CTRL_RESET;
            irq_enable <= 1'b0;
        end else if (wr_en) begin
            if (paddr == ADDR_REF_PIN_CTRL) begin
                ref_pin_ctrl <= pwdata[7:0] & REF_PIN_WMASK;
            end else if (paddr == ADDR_TIMING_CTRL) begin
                timing_ctrl <= pwdata[7:0] & TIMING_WMASK;
            end else if (paddr == ADDR_FLAG_CTRL) begin
                irq_enable <= pwdata[FLAG_IRQ_EN_BIT];
            end
        end
    end

    // Done flag: a completion in the clearing cycle wins over the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag <= 1'b0;
        end else if (done_event) begin
            done_flag <= 1'b1;
        end else if (wr_en && paddr == ADDR_FLAG_CTRL && !pwdata[FLAG_DONE_BIT]) begin
            done_flag <= 1'b0;
        end
    end

    assign conv_irq = done_flag && irq_enable;

    // =====================================
    // Result pair is reset only by power-on, so device resets keep it.
    // survives device reset
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            result_high <= 8'h00;
            result_low <= 8'h00;
        end else if (done_event) begin
            if (timing_ctrl[TIMING_JUSTIFY_BIT]) begin
                result_high <= {4'h0, sar_code[11:8]};
                result_low <= sar_code[7:0];
            end else begin
                result_high <= sar_code[11:4];
                result_low <= {sar_code[3:0], 4'h0};
            end
        end else if (wr_en && paddr == ADDR_RESULT_HIGH) begin
            result_high <= pwdata[7:0];
        end else if (wr_en && paddr == ADDR_RESULT_LOW) begin
            result_low <= pwdata[7:0];
        end
    end

    // =====================================
    // Conversion clock: divider from system clock, or free-running RC stand-in.
    // The divider stops in sleep; only the RC path keeps ticking there.
    // RC runs in sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count <= 7'd0;
            rc_count <= 8'd0;
        end else begin
            if (state == ST_IDLE || state == ST_DELAY || tick) begin
                div_count <= 7'd0;
            end else if (!sleep_mode) begin
                div_count <= div_count + 7'd1;
            end
            if (state == ST_IDLE || state == ST_DELAY || tick) begin
                rc_count <= 8'd0;
            end else begin
                rc_count <= rc_count + 8'd1;
            end
        end
    end

    assign tick = is_rc(timing_ctrl[2:0]) ? (rc_count == 8'(2 * RC_HALF_CYCLES - 1))
                  : (!sleep_mode && div_count == div_ratio(timing_ctrl[2:0]) - 7'd1);

    // =====================================
    // Sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            tick_count <= 5'd0;
            delay_count <= 3'd0;
        end else if (!main_ctrl[MAIN_ENABLE_BIT] || busy_clear_sw) begin
            // abort, result kept
            // A software abort in the gap restarts it; clearing the enable bit returns straight to idle without the pause.
            state <= ((state == ST_CONV || state == ST_GAP) && main_ctrl[MAIN_ENABLE_BIT]) ? ST_GAP : ST_IDLE;
            tick_count <= 5'd0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // A start taken during the gap waits in the busy bit and is served here.
                    if (busy_set || main_ctrl[MAIN_BUSY_BIT]) begin
                        tick_count <= 5'd0;
                        delay_count <= 3'd0;
                        if (is_rc(timing_ctrl[2:0])) begin
                            state <= ST_DELAY;
                        end else if (acq_periods(timing_ctrl[5:3]) == 5'd0) begin
                            state <= ST_CONV;
                        end else begin
                            state <= ST_ACQ;
                        end
                    end
                end
                ST_DELAY: begin
                    delay_count <= delay_count + 3'd1;
                    if (delay_count == 3'(TCY_CYCLES - 1)) begin
                        state <= (acq_periods(timing_ctrl[5:3]) == 5'd0) ? ST_CONV : ST_ACQ;
                    end
                end
                ST_ACQ: begin
                    if (tick) begin
                        tick_count <= tick_count + 5'd1;
                        if (tick_count == acq_periods(timing_ctrl[5:3]) - 5'd1) begin
                            state <= ST_CONV;
                            tick_count <= 5'd0;
                        end
                    end
                end
                ST_CONV: begin
                    if (tick) begin
                        tick_count <= tick_count + 5'd1;
                        if (tick_count == 5'(CONV_PERIODS - 1)) begin
                            state <= ST_GAP;
                            tick_count <= 5'd0;
                        end
                    end
                end
                default: begin
                    if (tick) begin
                        tick_count <= tick_count + 5'd1;
                        if (tick_count == 5'(GAP_PERIODS - 1)) begin
                            state <= ST_IDLE;
                            tick_count <= 5'd0;
                        end
                    end
                end
            endcase
        end
    end

    assign done_event = state == ST_CONV && tick && tick_count == 5'(CONV_PERIODS - 1)
                        && main_ctrl[MAIN_ENABLE_BIT] && !busy_clear_sw;
    assign sar_start = state != ST_CONV;

    sar_engine u_sar (
        .pclk(pclk),
        .presetn(presetn),
        .start(sar_start),
        .step(state == ST_CONV && tick),
        .comp_high(comp_high),
        .trial(dac_trial),
        .code(sar_code)
    );

    // =====================================
    // Analog controls; sampling resumes whenever enabled and not converting.
    always_comb begin
        analog_ctrl.channel = main_ctrl[5:2];
        analog_ctrl.sample_connect = main_ctrl[MAIN_ENABLE_BIT] && state != ST_CONV;
        analog_ctrl.ref_pos_external = ref_pin_ctrl[4];
        analog_ctrl.ref_neg_external = ref_pin_ctrl[5];
        // pin configuration
        // Code zero keeps every pin analog; any other code n leaves the top n+1 pins digital.
        for (int i = 0; i < 16; i++) begin
            analog_ctrl.analog_mode[i] = (ref_pin_ctrl[3:0] == 4'h0)
                                         || (5'(i) + {1'b0, ref_pin_ctrl[3:0]} < 5'h0f);
        end
    end

endmodule

// [testbench/sar_adc_sequencer_chk.sv]
// Checker of bus answers and analog-side controls at the sequencer ports.
`timescale 1ns/100ps
module sar_adc_sequencer_chk
    import adc_seq_pkg::*;
(
    input wire logic pclk, // System clock.
    input wire logic presetn, // Device reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    input wire logic [3:0] pstrb, // APB byte strobes.
    input wire logic [31:0] prdata, // APB read data.
    input wire logic pready, // APB ready.
    input wire logic pslverr, // APB error.
    input wire logic [11:0] dac_trial, // Trial value.
    input wire analog_ctrl_s analog_ctrl, // Analog controls.
    input wire logic conv_irq // Gated done flag.
);
    // ====================================
    // Shadow copies of control fields, updated only by taken writes.
    logic [7:0] sh_main; // Main control copy.
    logic [7:0] sh_ref; // Reference and pin copy.
    logic sh_irq_en; // Interrupt enable copy.
    logic acc; // Access phase in this cycle.
    logic bad; // Address outside the map.
    logic rd; // Read access.
    assign acc = psel && penable;
    assign rd = acc && !pwrite;
    assign bad = !(paddr inside {ADDR_MAIN_CTRL, ADDR_REF_PIN_CTRL, ADDR_TIMING_CTRL,
        ADDR_RESULT_HIGH, ADDR_RESULT_LOW, ADDR_FLAG_CTRL});

    // Pin code n leaves n+1 top channels digital, except code 0 which keeps all analog.
    function automatic logic [15:0] pin_mask(input logic [3:0] n);
        return (n == 4'h0) ? 16'hffff : 16'hffff >> (n + 1);
    endfunction

    // Shadows clear with the device reset, as the real controls do.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_main <= 8'h00;
            sh_ref <= 8'h00;
            sh_irq_en <= 1'b0;
        end else if (acc && pwrite && pstrb[0] && !bad) begin
            if (paddr == ADDR_MAIN_CTRL) begin
                sh_main <= pwdata[7:0];
            end
            if (paddr == ADDR_REF_PIN_CTRL) begin
                sh_ref <= pwdata[7:0];
            end
            if (paddr == ADDR_FLAG_CTRL) begin
                sh_irq_en <= pwdata[FLAG_IRQ_EN_BIT];
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    unmapped_err_a: assert property (acc |-> pslverr == bad)
        else $error("pslverr does not match the address map");
    upper_zero_a: assert property (rd |-> prdata[31:8] == 24'h0 && (!bad || prdata == 32'h0))
        else $error("read data has bits set outside the register");
    reserved_bit_a: assert property (rd && paddr == ADDR_TIMING_CTRL |-> !prdata[6])
        else $error("reserved timing bit reads one");
    pin_map_a: assert property (analog_ctrl.analog_mode == pin_mask(sh_ref[3:0]))
        else $error("analog pin mask wrong for pin code");
    ref_select_a: assert property ({analog_ctrl.ref_neg_external, analog_ctrl.ref_pos_external}
        == sh_ref[5:4])
        else $error("reference selection wrong");
    channel_route_a: assert property (analog_ctrl.channel == sh_main[5:2])
        else $error("routed channel differs from channel field");
    irq_gate_a: assert property (conv_irq |-> sh_irq_en)
        else $error("interrupt line high while disabled");
    // The engine reloads its trial value one cycle after leaving conversion, while sampling resumes.
    hold_open_a: assert property ($changed(dac_trial) |-> !$past(analog_ctrl.sample_connect, 2))
        else $error("trial value moves while input connected");
    idle_busy_a: assert property (rd && paddr == ADDR_MAIN_CTRL && !sh_main[0] |-> !prdata[1])
        else $error("busy reads one while converter disabled");
endmodule

bind sar_adc_sequencer sar_adc_sequencer_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dac_trial(dac_trial),
    .analog_ctrl(analog_ctrl), .conv_irq(conv_irq));

// [testbench/analog_array_model.sv]
// Behavioural analog array: channel levels, holding capacitor and comparator.
`timescale 1ns/100ps
module analog_array_model
    import adc_seq_pkg::*;
(
    input wire logic pclk, // System clock.
    input wire analog_ctrl_s analog_ctrl, // Channel and switch controls.
    input wire logic [15:0][11:0] levels, // Level on each input.
    input wire logic [11:0] dac_trial, // Trial value from the engine.
    output logic comp_high // Comparator decision.
);
    logic [11:0] held; // Charge on the holding capacitor.

    // channel tracking
    // The capacitor follows the routed input only while the switch is closed.
    always_ff @(posedge pclk) begin
        if (analog_ctrl.sample_connect) begin
            held <= levels[analog_ctrl.channel];
        end
    end

    // held comparison
    // Level changes after the switch opens never reach the decision.
    assign comp_high = held >= dac_trial;
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the converter sequencer with random levels.
`timescale 1ns/100ps
module testbench import adc_seq_pkg::*;;
    // ====================================
    // Stimulus and observation signals.
    logic pclk = 0;
    logic presetn = 0;
    logic por_n = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic sleep_mode = 0;
    logic [15:0][11:0] levels = '0;
    logic [31:0] prdata;
    logic pready, pslverr, comp_high, conv_irq;
    logic [11:0] dac_trial;
    analog_ctrl_s analog_ctrl;
    int n_fail = 0;
    int samples_checked = 0;
    int seed = 20;
    int cyc = 0;
    logic [31:0] q; // Last read data.
    logic err; // Last error answer.
    logic [7:0] eh, el; // Expected result pair.
    // Clocks of one conversion period per clock code, and periods per acquisition code.
    localparam int TICK[8] = '{2, 8, 32, 2 * RC_HALF_CYCLES, 4, 16, 64, 2 * RC_HALF_CYCLES};
    localparam int ACQ[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

    always #5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    sar_adc_sequencer i_dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
        .comp_high(comp_high), .dac_trial(dac_trial), .analog_ctrl(analog_ctrl), .conv_irq(conv_irq));
    analog_array_model i_ana (.pclk(pclk), .analog_ctrl(analog_ctrl), .levels(levels),
        .dac_trial(dac_trial), .comp_high(comp_high));

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask

    // One APB transfer; the request stands until pready is seen at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        err = pslverr;
        check(n < 20, "no ready");
        if (n == 20) conclude();
        psel <= 0;
        penable <= 0;
    endtask

    task automatic expect_rd(input logic [7:0] a, input logic [7:0] e, input string w);
        apb(0, a, 8'h00);
        check(q === {24'h0, e} && err === 1'b0, w);
    endtask

    // One conversion on a random channel with the given timing codes.
    task automatic conv(input logic [2:0] acq, input logic [2:0] ck, input logic jus);
        int t, lo, t0, n;
        logic [3:0] ch;
        logic [11:0] v;
        ch = 4'($random(seed));
        v = 12'($random(seed));
        levels[ch] <= v;
        sleep_mode <= (ck[1:0] == 2'b11);
        apb(1, ADDR_TIMING_CTRL, {jus, 1'b0, acq, ck});
        apb(1, ADDR_MAIN_CTRL, {2'b00, ch, 2'b01});
        repeat (6) @(posedge pclk);
        apb(1, ADDR_FLAG_CTRL, 8'h02);
        t = TICK[ck];
        lo = (ACQ[acq] + CONV_PERIODS) * t + (ck[1:0] == 2'b11 ? TCY_CYCLES : 0);
        apb(1, ADDR_MAIN_CTRL, {2'b00, ch, 2'b11});
        t0 = cyc;
        if (acq == 3'h0) levels[ch] <= ~v;
        for (n = 0; n < 4000; n++) begin
            apb(0, ADDR_MAIN_CTRL, 8'h00);
            if (n == 0) check(q[MAIN_BUSY_BIT] === 1'b1, "busy low while working");
            if (q[MAIN_BUSY_BIT] === 1'b0) break;
        end
        check(n < 4000, "conversion never ends");
        if (n == 4000) conclude();
        check(cyc - t0 >= lo - t && cyc - t0 <= lo + t + 12, "conversion time");
        eh = jus ? {4'h0, v[11:8]} : v[11:4];
        el = jus ? v[7:0] : {v[3:0], 4'h0};
        check(conv_irq === 1'b1, "interrupt line low");
        expect_rd(ADDR_FLAG_CTRL, 8'h03, "done flag");
        expect_rd(ADDR_RESULT_HIGH, eh, "result high");
        expect_rd(ADDR_RESULT_LOW, el, "result low");
        repeat (2 * t + 6) @(posedge pclk);
        check(analog_ctrl.sample_connect === 1'b1, "sampling not resumed");
        sleep_mode <= 0;
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        por_n <= 1;
        for (int i = 0; i < 6; i++) expect_rd(8'(4 * i), 8'h00, "reset value");
        apb(1, ADDR_TIMING_CTRL, 8'hff);
        expect_rd(ADDR_TIMING_CTRL, 8'hbf, "timing bits");
        apb(1, ADDR_MAIN_CTRL, 8'hfc);
        expect_rd(ADDR_MAIN_CTRL, 8'h3c, "main bits");
        apb(0, 8'h18, 8'h00);
        check(q === 32'h0, "unmapped read");
        check(err === 1'b1, "no error on unmapped read");
        for (int p = 0; p < 16; p++) apb(1, ADDR_REF_PIN_CTRL, 8'(p + 16 * (p % 4)));
        apb(1, ADDR_REF_PIN_CTRL, 8'h00);
        for (int i = 0; i < 8; i++) conv(3'(i), 3'(i), i[0]);
        apb(1, ADDR_FLAG_CTRL, 8'h02);
        apb(1, ADDR_TIMING_CTRL, 8'h3a);
        apb(1, ADDR_MAIN_CTRL, 8'h03);
        repeat (736) @(posedge pclk);
        apb(1, ADDR_MAIN_CTRL, 8'h01);
        expect_rd(ADDR_RESULT_HIGH, eh, "abort high");
        expect_rd(ADDR_RESULT_LOW, el, "abort low");
        expect_rd(ADDR_FLAG_CTRL, 8'h02, "abort flag");
        repeat (80) @(posedge pclk);
        apb(1, ADDR_MAIN_CTRL, 8'h03);
        repeat (100) @(posedge pclk);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 3; i++) expect_rd(8'(4 * i), 8'h00, "control after reset");
        expect_rd(ADDR_FLAG_CTRL, 8'h00, "flag after reset");
        expect_rd(ADDR_RESULT_HIGH, eh, "high kept");
        expect_rd(ADDR_RESULT_LOW, el, "low kept");
        apb(1, ADDR_MAIN_CTRL, 8'h02);
        repeat (20) @(posedge pclk);
        expect_rd(ADDR_MAIN_CTRL, 8'h00, "start while disabled");
        conclude();
    end
endmodule
